/* File: usb_phy_ctrl_regs.svh */
// Purpose: Register indices, field positions and reset values of the USB PHY control block
// Assumes: Register byte address is four times its index
// Notes: Definitions only
`ifndef USB_PHY_CTRL_REGS_SVH
`define USB_PHY_CTRL_REGS_SVH

`define IDX_USB_PHY_SETUP 16'hf008
`define IDX_USB_PHY_RESET_CONTROL 16'hf00a
`define IDX_USB_PORT_ADAPTER_SETUP 16'hf00c
`define IDX_USB_PHY_STATE 16'hf011
`define IDX_BYTE_SHIFT 2

`define SETUP_OSC_HI 14
`define SETUP_OSC_LO 12
`define SETUP_ID_PAD 11
`define SETUP_LPM 10
`define SETUP_PLL 9
`define SETUP_STUFF 8
`define SETUP_DM_PD 7
`define SETUP_DP_PD 6
`define SETUP_SUSPEND_N 5
`define SETUP_OPMODE_HI 4
`define SETUP_OPMODE_LO 3
`define SETUP_TERM 2
`define SETUP_XCVR_HI 1
`define SETUP_XCVR_LO 0
`define SETUP_RESET 15'h102d

`define RSTCTL_XCVR_IF 1
`define RSTCTL_PON 0
`define RSTCTL_RESET 2'h2

`define ADAPT_FLAG_MODE 1
`define ADAPT_GATE_VALID 0
`define ADAPT_RESET 2'h0

`define STATE_SELF_TEST 4
`define STATE_ID_PAD 3
`define STATE_DISCONNECT 2
`define STATE_LINE_HI 1
`define STATE_LINE_LO 0

`define AXI_RESP_OKAY 2'h0
`define AXI_RESP_SLVERR 2'h2

`endif

/* File: usb_phy_ctrl_pkg.sv */
// Purpose: Types shared by the USB PHY control block
// Assumes: Nothing beyond the register header
// Notes: Encodings follow the UTMI signal values
package usb_phy_ctrl_pkg;
  typedef enum logic [1:0] {
    LINE_SE0 = 2'h0,
    LINE_J = 2'h1,
    LINE_K = 2'h2,
    LINE_SE1 = 2'h3
  } line_state_t;
  typedef logic [1:0] op_mode_t;
  typedef logic [1:0] xcvr_select_t;
  typedef logic [2:0] osc_code_t;
endpackage

/* File: rx_flag_if.sv */
// Purpose: Carries adapter settings and synchronised line state to the flag mapper
// Assumes: Single clock domain
// Notes: Driven by the register block, read by the mapper
interface rx_flag_if;
  logic flag_mode;
  logic valid_gated_by_active;
  usb_phy_ctrl_pkg::line_state_t line_state;
  modport regs (output flag_mode, output valid_gated_by_active, output line_state);
  modport mapper (input flag_mode, input valid_gated_by_active, input line_state);
endinterface

/* File: usb_rx_flag_mapper.sv */
// Purpose: Maps PHY receive status onto two one-bit processor flags
// Assumes: rx_active and rx_valid come from the PHY clock domain
// Notes: Flags are registered, three cycles behind the pins
module usb_rx_flag_mapper (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Settings
  rx_flag_if.mapper cfg,
  // PHY receive status
  input wire logic rx_active,
  input wire logic rx_valid,
  // Processor flags
  output logic flag_a,
  output logic flag_b
);
  import usb_phy_ctrl_pkg::*;

  logic [1:0] active_sync;
  logic [1:0] valid_sync;
  logic next_a;
  logic next_b;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      active_sync <= 2'h0;
      valid_sync <= 2'h0;
    end else begin
      active_sync <= {active_sync[0], rx_active};
      valid_sync <= {valid_sync[0], rx_valid};
    end
  end

  always_comb begin
    if (cfg.flag_mode) begin
      next_a = cfg.line_state[0]; // [R14]
      next_b = cfg.line_state[1]; // [R14]
    end else begin
      next_a = active_sync[1]; // [R13]
      next_b = cfg.valid_gated_by_active ? (valid_sync[1] & active_sync[1])
                                         : valid_sync[1]; // [R15]
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flag_a <= 1'b0;
      flag_b <= 1'b0;
    end else begin
      flag_a <= next_a;
      flag_b <= next_b;
    end
  end
endmodule

/* File: usb_phy_utmi_control_shim.sv */
// Purpose: AXI4-Lite register block driving the static UTMI controls of an on-chip USB PHY
// Assumes: PHY status inputs are asynchronous to aclk and pass two flip-flops
// Notes: Write answers two cycles after both channels are taken, reads one cycle after
//
// Function
// [R1] Three-bit oscillator code drives PHY reference setting, resets to 1
// [R2] Setup bit 11 enables ID pad detection, resets to 0
// [R3] Setup bit 10 enables link power management, resets to 0
// [R4] Setup bit 9 enables the PHY PLL, resets to 0
// [R5] Setup bit 8 enables transmit bit stuffing, resets to 0
// [R6] Setup bits 7 and 6 enable D-minus and D-plus pulldowns, reset 0
// [R7] Setup bit 5 drives SuspendM directly, resets to 1
// [R8] Setup bits 4:3 drive OpMode directly, reset to 1
// [R9] Setup bit 2 drives TermSelect directly, resets to 1
// [R10] Setup bits 1:0 drive XcvrSelect directly, reset to 1
// [R11] Reset-control bit 1 holds transceiver interface in reset until cleared
// [R12] Reset-control bit 0 releases PHY power-on reset when set
// [R13] Two processor flags carry receive status from the PHY
// [R14] Adapter bit 1 selects line state instead of active and valid
// [R15] Adapter bit 0 gates receive-valid flag with receive-active
// [R16] Status bit 4 shows PHY self-test passed, resets to 0
// [R17] Status bit 3 shows ID pad above 100 kilohm, resets to 0
// [R18] Status bit 2 shows no device attached
// [R19] Status bits 1:0 show UTMI line state
// [R20] Reserved bits read zero; status register ignores writes
`include "usb_phy_ctrl_regs.svh"

module usb_phy_utmi_control_shim #(
  parameter int ADDR_W = 18
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write address
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // AXI4-Lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read address
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // UTMI static controls toward the PHY
  output usb_phy_ctrl_pkg::osc_code_t osc_freq_select,
  output logic id_pin_detect_enable,
  output logic link_power_mgmt_enable,
  output logic phy_pll_enable,
  output logic tx_stuffing_enable,
  output logic dminus_pulldown_enable,
  output logic dplus_pulldown_enable,
  output logic suspend_n,
  output usb_phy_ctrl_pkg::op_mode_t op_mode,
  output logic termination_select_value,
  output usb_phy_ctrl_pkg::xcvr_select_t xcvr_select,
  // PHY resets
  output logic transceiver_if_reset,
  output logic phy_poweron_reset_release,
  // PHY status inputs
  input wire logic self_test_passed,
  input wire logic id_pad_high_resistance,
  input wire logic no_device_attached,
  input wire usb_phy_ctrl_pkg::line_state_t bus_line_state,
  input wire logic rx_active,
  input wire logic rx_valid,
  // Receive flags toward the processor
  output logic rx_flag_a,
  output logic rx_flag_b
);
  import usb_phy_ctrl_pkg::*;

  localparam int IDX_W = ADDR_W - `IDX_BYTE_SHIFT;

  // Write channel holding state
  logic aw_held;
  logic w_held;
  logic [IDX_W-1:0] aw_index;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic do_write;

  // Register fields
  logic flag_mode;
  logic valid_gated_by_active;

  // Status synchronisers
  logic [4:0] status_meta;
  logic [4:0] status_sync;

  rx_flag_if flag_bus ();

  // Byte-lane merge of a write into an existing word
  function automatic logic [31:0] merge_word(input logic [31:0] old_word,
                                             input logic [31:0] new_word,
                                             input logic [3:0] strb);
    logic [31:0] merged;
    merged = old_word;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        merged[8*b +: 8] = new_word[8*b +: 8];
      end
    end
    return merged;
  endfunction

  function automatic logic index_mapped(input logic [IDX_W-1:0] idx);
    return (idx == IDX_W'(`IDX_USB_PHY_SETUP)) ||
           (idx == IDX_W'(`IDX_USB_PHY_RESET_CONTROL)) ||
           (idx == IDX_W'(`IDX_USB_PORT_ADAPTER_SETUP)) ||
           (idx == IDX_W'(`IDX_USB_PHY_STATE));
  endfunction

  // Current contents of each register as a word, and each writable word with a write merged in
  logic [31:0] setup_word;
  logic [31:0] reset_ctl_word;
  logic [31:0] adapter_word;
  logic [31:0] state_word;
  logic [31:0] next_setup;
  logic [31:0] next_reset_ctl;
  logic [31:0] next_adapter;

  always_comb begin
    setup_word = 32'h0; // [R20]
    setup_word[`SETUP_OSC_HI:`SETUP_OSC_LO] = osc_freq_select;
    setup_word[`SETUP_ID_PAD] = id_pin_detect_enable;
    setup_word[`SETUP_LPM] = link_power_mgmt_enable;
    setup_word[`SETUP_PLL] = phy_pll_enable;
    setup_word[`SETUP_STUFF] = tx_stuffing_enable;
    setup_word[`SETUP_DM_PD] = dminus_pulldown_enable;
    setup_word[`SETUP_DP_PD] = dplus_pulldown_enable;
    setup_word[`SETUP_SUSPEND_N] = suspend_n;
    setup_word[`SETUP_OPMODE_HI:`SETUP_OPMODE_LO] = op_mode;
    setup_word[`SETUP_TERM] = termination_select_value;
    setup_word[`SETUP_XCVR_HI:`SETUP_XCVR_LO] = xcvr_select;
  end

  always_comb begin
    reset_ctl_word = 32'h0; // [R20]
    reset_ctl_word[`RSTCTL_XCVR_IF] = transceiver_if_reset;
    reset_ctl_word[`RSTCTL_PON] = phy_poweron_reset_release;
    adapter_word = 32'h0;
    adapter_word[`ADAPT_FLAG_MODE] = flag_mode;
    adapter_word[`ADAPT_GATE_VALID] = valid_gated_by_active;
    state_word = 32'h0;
    state_word[`STATE_SELF_TEST] = status_sync[4]; // [R16]
    state_word[`STATE_ID_PAD] = status_sync[3]; // [R17]
    state_word[`STATE_DISCONNECT] = status_sync[2]; // [R18]
    state_word[`STATE_LINE_HI:`STATE_LINE_LO] = status_sync[1:0]; // [R19]
  end

  always_comb begin
    next_setup = merge_word(setup_word, w_data, w_strb);
    next_reset_ctl = merge_word(reset_ctl_word, w_data, w_strb);
    next_adapter = merge_word(adapter_word, w_data, w_strb);
  end

  // Write address and data are taken in either order and held until used
  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready = !w_held && !s_axi_bvalid;
  assign do_write = aw_held && w_held && !s_axi_bvalid;

  // One strobe per writable register; the status index has none, so writes there vanish
  // Protection attributes are accepted on both address channels and carry no meaning here
  logic wr_setup;
  logic wr_reset_ctl;
  logic wr_adapter;

  assign wr_setup = do_write && (aw_index == IDX_W'(`IDX_USB_PHY_SETUP));
  assign wr_reset_ctl = do_write && (aw_index == IDX_W'(`IDX_USB_PHY_RESET_CONTROL));
  assign wr_adapter = do_write && (aw_index == IDX_W'(`IDX_USB_PORT_ADAPTER_SETUP));

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      aw_index <= '0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held <= 1'b1;
      aw_index <= s_axi_awaddr[ADDR_W-1:`IDX_BYTE_SHIFT];
    end else if (do_write) begin
      aw_held <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held <= 1'b0;
      w_data <= 32'h0;
      w_strb <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held <= 1'b1;
      w_data <= s_axi_wdata;
      w_strb <= s_axi_wstrb;
    end else if (do_write) begin
      w_held <= 1'b0;
    end
  end

  // Unmapped writes get SLVERR; writes to the status word are dropped but answered OKAY
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `AXI_RESP_OKAY;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= index_mapped(aw_index) ? `AXI_RESP_OKAY : `AXI_RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Setup register fields, each driven straight to the PHY
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      osc_freq_select <= osc_code_t'(`SETUP_RESET >> `SETUP_OSC_LO); // [R1]
      id_pin_detect_enable <= 1'b0; // [R2]
      link_power_mgmt_enable <= 1'b0; // [R3]
      phy_pll_enable <= 1'b0; // [R4]
      tx_stuffing_enable <= 1'b0; // [R5]
      dminus_pulldown_enable <= 1'b0; // [R6]
      dplus_pulldown_enable <= 1'b0; // [R6]
      suspend_n <= 1'b1; // [R7]
      op_mode <= op_mode_t'(`SETUP_RESET >> `SETUP_OPMODE_LO); // [R8]
      termination_select_value <= 1'b1; // [R9]
      xcvr_select <= xcvr_select_t'(`SETUP_RESET); // [R10]
    end else if (wr_setup) begin
      osc_freq_select <= next_setup[`SETUP_OSC_HI:`SETUP_OSC_LO]; // [R1]
      id_pin_detect_enable <= next_setup[`SETUP_ID_PAD]; // [R2]
      link_power_mgmt_enable <= next_setup[`SETUP_LPM]; // [R3]
      phy_pll_enable <= next_setup[`SETUP_PLL]; // [R4]
      tx_stuffing_enable <= next_setup[`SETUP_STUFF]; // [R5]
      dminus_pulldown_enable <= next_setup[`SETUP_DM_PD]; // [R6]
      dplus_pulldown_enable <= next_setup[`SETUP_DP_PD]; // [R6]
      suspend_n <= next_setup[`SETUP_SUSPEND_N]; // [R7]
      op_mode <= next_setup[`SETUP_OPMODE_HI:`SETUP_OPMODE_LO]; // [R8]
      termination_select_value <= next_setup[`SETUP_TERM]; // [R9]
      xcvr_select <= next_setup[`SETUP_XCVR_HI:`SETUP_XCVR_LO]; // [R10]
    end
  end

  // PHY stays in power-on reset and the transceiver interface held until software acts
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      transceiver_if_reset <= 1'(`RSTCTL_RESET >> `RSTCTL_XCVR_IF); // [R11]
      phy_poweron_reset_release <= 1'b0; // [R12]
    end else if (wr_reset_ctl) begin
      transceiver_if_reset <= next_reset_ctl[`RSTCTL_XCVR_IF]; // [R11]
      phy_poweron_reset_release <= next_reset_ctl[`RSTCTL_PON]; // [R12]
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flag_mode <= 1'b0; // [R14]
      valid_gated_by_active <= 1'b0; // [R15]
    end else if (wr_adapter) begin
      flag_mode <= next_adapter[`ADAPT_FLAG_MODE]; // [R14]
      valid_gated_by_active <= next_adapter[`ADAPT_GATE_VALID]; // [R15]
    end
  end

  // PHY status crosses from its own domain; bits may be caught mid-change
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      status_meta <= 5'h00;
      status_sync <= 5'h00;
    end else begin
      status_meta <= {self_test_passed, id_pad_high_resistance, no_device_attached,
                      bus_line_state};
      status_sync <= status_meta;
    end
  end

  // Read channel: one read at a time, answered the cycle after the address
  assign s_axi_arready = !s_axi_rvalid;

  // Decoded from the live address so the word is ready at the edge that takes it
  logic [31:0] read_word;
  logic [1:0] read_resp;

  always_comb begin
    read_word = 32'h0;
    read_resp = `AXI_RESP_OKAY;
    case (s_axi_araddr[ADDR_W-1:`IDX_BYTE_SHIFT])
      IDX_W'(`IDX_USB_PHY_SETUP): begin
        read_word = setup_word;
      end
      IDX_W'(`IDX_USB_PHY_RESET_CONTROL): begin
        read_word = reset_ctl_word;
      end
      IDX_W'(`IDX_USB_PORT_ADAPTER_SETUP): begin
        read_word = adapter_word;
      end
      IDX_W'(`IDX_USB_PHY_STATE): begin
        read_word = state_word;
      end
      default: begin
        read_resp = `AXI_RESP_SLVERR; // [R20]
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= `AXI_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= read_word;
      s_axi_rresp <= read_resp;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // Mapper sees the already synchronised line state, so both paths agree
  assign flag_bus.flag_mode = flag_mode;
  assign flag_bus.valid_gated_by_active = valid_gated_by_active;
  assign flag_bus.line_state = line_state_t'(status_sync[1:0]);

  usb_rx_flag_mapper u_flag_mapper (
    .aclk(aclk),
    .aresetn(aresetn),
    .cfg(flag_bus.mapper),
    .rx_active(rx_active),
    .rx_valid(rx_valid),
    .flag_a(rx_flag_a),
    .flag_b(rx_flag_b)
  );
endmodule

/* File: usb_phy_model.sv */
// Purpose: Stand-in for the PHY status pins seen by the control block
// Assumes: The bench drives the stimulus word just after a clock edge
// Notes: Pins are plain levels; the block synchronises them itself
module usb_phy_model (
  // Stimulus from the bench
  input wire logic [6:0] drive,
  // PHY status toward the block
  output logic self_test_passed,
  output logic id_pad_high_resistance,
  output logic no_device_attached,
  output usb_phy_ctrl_pkg::line_state_t bus_line_state,
  output logic rx_active,
  output logic rx_valid
);
  import usb_phy_ctrl_pkg::*;
  // Driven every cycle, never left floating, so no stale value can pass for a fresh one
  assign self_test_passed = drive[6];
  assign id_pad_high_resistance = drive[5];
  assign no_device_attached = drive[4];
  assign bus_line_state = line_state_t'(drive[3:2]);
  assign rx_active = drive[1];
  assign rx_valid = drive[0];
endmodule

/* File: usb_phy_utmi_control_shim_properties.sv */
// Purpose: Concurrent checks on the ports of the USB PHY control block
// Assumes: One clock, synchronous active-low reset
// Notes: Attached by bind from the testbench top
module usb_phy_utmi_control_shim_properties (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Register bus handshakes
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // PHY controls
  input wire usb_phy_ctrl_pkg::osc_code_t osc_freq_select,
  input wire logic id_pin_detect_enable,
  input wire logic link_power_mgmt_enable,
  input wire logic phy_pll_enable,
  input wire logic tx_stuffing_enable,
  input wire logic dminus_pulldown_enable,
  input wire logic dplus_pulldown_enable,
  input wire logic suspend_n,
  input wire usb_phy_ctrl_pkg::op_mode_t op_mode,
  input wire logic termination_select_value,
  input wire usb_phy_ctrl_pkg::xcvr_select_t xcvr_select,
  input wire logic transceiver_if_reset,
  input wire logic phy_poweron_reset_release,
  // Receive status and flags
  input wire usb_phy_ctrl_pkg::line_state_t bus_line_state,
  input wire logic rx_active,
  input wire logic rx_valid,
  input wire logic rx_flag_a,
  input wire logic rx_flag_b
);
  import usb_phy_ctrl_pkg::*;
  wire [16:0] ctl_bits = {osc_freq_select, id_pin_detect_enable, link_power_mgmt_enable,
    phy_pll_enable, tx_stuffing_enable, dminus_pulldown_enable, dplus_pulldown_enable,
    suspend_n, op_mode, termination_select_value, xcvr_select, transceiver_if_reset,
    phy_poweron_reset_release};
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  AST_CTL_RESET: assert property ($rose(aresetn) |-> ctl_bits == {15'h102d, 2'b10})
    else $error("PHY controls not at reset values after reset");
  AST_CTL_ONLY_ON_WRITE: assert property ($changed(ctl_bits) |-> $rose(s_axi_bvalid))
    else $error("PHY control changed without a write answer");
  AST_WRITE_ANSWER: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid &&
    s_axi_wready |-> ##2 s_axi_bvalid)
    else $error("Write answer late");
  AST_READ_ANSWER: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("Read answer late");
  AST_B_STANDS: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp))
    else $error("Write response dropped before acceptance");
  AST_R_STANDS: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata))
    else $error("Read data dropped before acceptance");
  AST_NO_TAKE_WHILE_ANSWER: assert property (s_axi_bvalid |->
    !s_axi_awready && !s_axi_wready)
    else $error("Write channels ready while response pending");
  AST_FLAGS_QUIET: assert property (!$past(rx_active, 3) && !$past(rx_valid, 3) &&
    $past(bus_line_state, 3) == LINE_SE0 |-> !rx_flag_a && !rx_flag_b)
    else $error("Flag set with all receive status low");
endmodule

/* File: test_usb_phy_utmi_control_shim.sv */
// Purpose: Self-checking bench for the USB PHY control block
// Assumes: Register byte address is four times the register index
// Notes: Read and write answers are compared by a monitor against queued expectations
`include "usb_phy_ctrl_regs.svh"

module test_usb_phy_utmi_control_shim;
  timeunit 1ns;
  timeprecision 1ps;
  import usb_phy_ctrl_pkg::*;
  localparam logic [17:0] A_SETUP = {`IDX_USB_PHY_SETUP, 2'b00};
  localparam logic [17:0] A_RST = {`IDX_USB_PHY_RESET_CONTROL, 2'b00};
  localparam logic [17:0] A_ADAPT = {`IDX_USB_PORT_ADAPTER_SETUP, 2'b00};
  localparam logic [17:0] A_STATE = {`IDX_USB_PHY_STATE, 2'b00};
  localparam logic [17:0] A_UNMAP = {16'hf009, 2'b00};
  logic aclk = 0, aresetn = 0;
  logic [17:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [2:0] s_axi_awprot = '0, s_axi_arprot = '0;
  logic [31:0] s_axi_wdata = '0;
  logic [3:0] s_axi_wstrb = '0;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic s_axi_arvalid = 0, s_axi_rready = 0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  osc_code_t osc_freq_select;
  op_mode_t op_mode;
  xcvr_select_t xcvr_select;
  logic id_pin_detect_enable, link_power_mgmt_enable, phy_pll_enable, tx_stuffing_enable;
  logic dminus_pulldown_enable, dplus_pulldown_enable, suspend_n, termination_select_value;
  logic transceiver_if_reset, phy_poweron_reset_release, rx_flag_a, rx_flag_b;
  logic self_test_passed, id_pad_high_resistance, no_device_attached, rx_active, rx_valid;
  line_state_t bus_line_state;
  logic [6:0] phy_drive = '0;
  wire [14:0] setup_bits = {osc_freq_select, id_pin_detect_enable, link_power_mgmt_enable,
    phy_pll_enable, tx_stuffing_enable, dminus_pulldown_enable, dplus_pulldown_enable,
    suspend_n, op_mode, termination_select_value, xcvr_select};
  logic [1:0] exp_b[$];
  logic [33:0] exp_r[$];
  int num_errors = 0, checked = 0, seed = 16;
  int osc_codes[6] = '{0, 3, 4, 5, 6, 1};
  logic [31:0] d;

  always #25 aclk = ~aclk;

  usb_phy_utmi_control_shim #(.ADDR_W(18)) dut_u (.aclk, .aresetn, .s_axi_awaddr,
    .s_axi_awprot, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arprot, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .osc_freq_select, .id_pin_detect_enable,
    .link_power_mgmt_enable, .phy_pll_enable, .tx_stuffing_enable, .dminus_pulldown_enable,
    .dplus_pulldown_enable, .suspend_n, .op_mode, .termination_select_value, .xcvr_select,
    .transceiver_if_reset, .phy_poweron_reset_release, .self_test_passed,
    .id_pad_high_resistance, .no_device_attached, .bus_line_state, .rx_active, .rx_valid,
    .rx_flag_a, .rx_flag_b);

  usb_phy_model phy_u (.drive(phy_drive), .self_test_passed, .id_pad_high_resistance,
    .no_device_attached, .bus_line_state, .rx_active, .rx_valid);

  task automatic chk(input logic [33:0] seen, input logic [33:0] exp);
    checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic end_sim;
    $display("Comparisons %0d, mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // Ready is raised late at random so the answer must stand while it waits
  task automatic wr(input logic [17:0] a, input logic [31:0] v, input logic [3:0] s,
                    input logic [1:0] r);
    bit aw_done;
    bit w_done;
    aw_done = 0;
    w_done = 0;
    exp_b.push_back(r);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    while (!(aw_done && w_done)) begin
      @(posedge aclk);
      if (!aw_done && s_axi_awready) begin
        aw_done = 1;
        s_axi_awvalid <= 1'b0;
      end
      if (!w_done && s_axi_wready) begin
        w_done = 1;
        s_axi_wvalid <= 1'b0;
      end
    end
    repeat ($random(seed) & 3) @(posedge aclk);
    s_axi_bready <= 1'b1;
    do @(posedge aclk); while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    @(posedge aclk);
  endtask

  task automatic rd(input logic [17:0] a, input logic [33:0] e);
    exp_r.push_back(e);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    repeat ($random(seed) & 3) @(posedge aclk);
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    @(posedge aclk);
  endtask

  function automatic logic [1:0] flag_exp(input logic [1:0] m, input logic [6:0] p);
    if (m[1])
      return {p[2], p[3]};
    return {p[1], p[0] & (p[1] | !m[0])};
  endfunction

  always @(posedge aclk) begin
    if (s_axi_bvalid && s_axi_bready)
      chk(34'(s_axi_bresp), 34'(exp_b.pop_front()));
    if (s_axi_rvalid && s_axi_rready)
      chk({s_axi_rresp, s_axi_rdata}, exp_r.pop_front());
  end

  initial begin
    repeat (20000) @(posedge aclk);
    num_errors++;
    end_sim();
  end

  initial begin
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    chk(34'({setup_bits, transceiver_if_reset, phy_poweron_reset_release}), 34'h40b6);
    chk(34'({rx_flag_a, rx_flag_b}), 34'h0);
    rd(A_SETUP, 34'h102d);
    rd(A_RST, 34'h2);
    rd(A_ADAPT, 34'h0);
    rd(A_STATE, 34'h0);
    foreach (osc_codes[i]) begin
      d = ($random(seed) & 32'hffff8fff) | (32'(osc_codes[i]) << 12);
      wr(A_SETUP, d, 4'hf, `AXI_RESP_OKAY);
      chk(34'(setup_bits), 34'(d[14:0]));
      rd(A_SETUP, 34'(d & 32'h7fff));
    end
    // Only byte lane 1 enabled: lower byte must survive
    wr(A_SETUP, 32'h0, 4'h2, `AXI_RESP_OKAY);
    rd(A_SETUP, 34'(d[7:0]));
    wr(A_UNMAP, 32'hffffffff, 4'hf, `AXI_RESP_SLVERR);
    rd(A_UNMAP, {`AXI_RESP_SLVERR, 32'h0});
    chk(34'(setup_bits), 34'(d[7:0]));
    wr(A_RST, 32'hfffffffc, 4'hf, `AXI_RESP_OKAY);
    chk(34'({transceiver_if_reset, phy_poweron_reset_release}), 34'h0);
    rd(A_RST, 34'h0);
    wr(A_RST, 32'h1, 4'hf, `AXI_RESP_OKAY);
    chk(34'({transceiver_if_reset, phy_poweron_reset_release}), 34'h1);
    repeat (4) begin
      phy_drive <= 7'($random(seed));
      repeat (3) @(posedge aclk);
      rd(A_STATE, 34'(phy_drive[6:2]));
    end
    wr(A_STATE, 32'hffffffff, 4'hf, `AXI_RESP_OKAY);
    rd(A_STATE, 34'(phy_drive[6:2]));
    for (int m = 0; m < 4; m++) begin
      wr(A_ADAPT, 32'(m) | 32'hfffffffc, 4'hf, `AXI_RESP_OKAY);
      rd(A_ADAPT, 34'(m));
      repeat (6) begin
        phy_drive <= 7'($random(seed));
        repeat (5) @(posedge aclk);
        chk(34'({rx_flag_a, rx_flag_b}), 34'(flag_exp(2'(m), phy_drive)));
      end
    end
    end_sim();
  end
endmodule

bind usb_phy_utmi_control_shim usb_phy_utmi_control_shim_properties props_u (.aclk, .aresetn,
  .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
  .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready,
  .osc_freq_select, .id_pin_detect_enable, .link_power_mgmt_enable, .phy_pll_enable,
  .tx_stuffing_enable, .dminus_pulldown_enable, .dplus_pulldown_enable, .suspend_n, .op_mode,
  .termination_select_value, .xcvr_select, .transceiver_if_reset, .phy_poweron_reset_release,
  .bus_line_state, .rx_active, .rx_valid, .rx_flag_a, .rx_flag_b);
